// >>> dv/pti_chk.sv
`timescale 1ns/1ps
module pti_chk (
  // clock, reset and watched ports
  input wire logic clk_sys, rst_n, ad_oe, par_out, par_oe, ctl_oe,
  input wire logic trdy_n_out, stop_n_out, devsel_n_out, perr_n_out,
  input wire logic perr_oe, serr_oe, inta_n_out, inta_oe, user_irq,
  input wire logic fatal_err, req_valid,
  input wire logic [31:0] ad_out,
  input wire pti_pkg::pti_bus_in_t bus_in
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // drive enables and target timing
  a_rst_float: assert property (disable iff (1'b0) !rst_n |->
    !(ad_oe | ctl_oe | perr_oe | serr_oe | inta_oe)) else $error("oe in reset");
  a_par_lag: assert property (par_oe == $past(ad_oe))
    else $error("par oe lag");
  a_par_even: assert property (par_oe |->
    par_out == ^{$past(ad_out), $past(bus_in.cbe_n)}) else $error("par odd");
  a_trdy_claim: assert property (ctl_oe && !trdy_n_out |-> !devsel_n_out)
    else $error("trdy no devsel");
  a_ad_selected: assert property (ad_oe |-> ctl_oe)
    else $error("ad unselected");
  a_stop_claim: assert property (ctl_oe && !stop_n_out |-> !devsel_n_out)
    else $error("stop no devsel");
  a_ctl_exit_high: assert property ($fell(ctl_oe) |->
    $past(trdy_n_out & stop_n_out & devsel_n_out)) else $error("ctl release");
  a_perr_pulse: assert property (perr_oe && !perr_n_out |=>
    perr_oe && perr_n_out ##1 !perr_oe) else $error("perr shape");
  a_inta_level: assert property (inta_oe == $past(user_irq) &&
    (!inta_oe || !inta_n_out)) else $error("inta level");
  a_serr_fatal: assert property ($rose(fatal_err) |-> ##[1:3] serr_oe)
    else $error("serr missing");
  // main scenarios reached
  c_phase: cover property (req_valid);
  c_stop: cover property (ctl_oe && !stop_n_out);
  c_perr: cover property (perr_oe && !perr_n_out);
endmodule // pti_chk
bind pti_target pti_chk u_chk (.clk_sys, .rst_n, .ad_oe, .par_out, .par_oe,
  .ctl_oe, .trdy_n_out, .stop_n_out, .devsel_n_out, .perr_n_out, .perr_oe,
  .serr_oe, .inta_n_out, .inta_oe, .user_irq, .fatal_err, .req_valid,
  .ad_out, .bus_in);

// >>> dv/pti_master.sv
`timescale 1ns/1ps
module pti_master (
  // clock and target drive
  input wire logic clk_sys, ad_oe, par_oe, par_out, trdy_n_out, stop_n_out,
  input wire logic [31:0] ad_out,
  // resolved bus to the target
  output pti_pkg::pti_bus_in_t bus_in
);
  pti_pkg::pti_bus_in_t m = '{default: '1};
  // ad and par wires resolved from both drivers
  always_comb begin
    bus_in = m;
    bus_in.ad = ad_oe ? ad_out : m.ad;
    bus_in.par = par_oe ? par_out : m.par;
  end
  // single-phase transfer; st bit 0 ready seen, bit 1 stop seen
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, d,
    input logic wr, ids, bad, output logic [31:0] rd, output int st);
    st = 0;
    repeat (4) @(posedge clk_sys);
    m.frame_n <= 1'b0;
    m.ad <= a;
    m.cbe_n <= cmd;
    m.idsel <= ids;
    @(posedge clk_sys);
    m.par <= ^{a, cmd};
    m.frame_n <= 1'b1;
    m.irdy_n <= 1'b0;
    m.cbe_n <= 4'h0;
    m.ad <= wr ? d : ~a;
    m.idsel <= 1'b0;
    for (int i = 0; i < 9 && st == 0; i++) begin
      @(posedge clk_sys);
      m.par <= bad ^ (^d);
      if (!trdy_n_out || !stop_n_out)
        st = (trdy_n_out ? 0 : 1) + (stop_n_out ? 0 : 2);
    end
    rd = bus_in.ad;
    m.irdy_n <= 1'b1;
    m.ad <= ~m.ad;
  endtask
endmodule // pti_master

// >>> dv/tb.sv
`timescale 1ns/1ps
`include "pti_regs.svh"
module tb;
  import pti_pkg::*;
  logic clk_sys = 0, rst_n, user_ready = 1, user_stop = 0;
  logic user_irq = 0, fatal_err = 0, ad_oe, par_out, par_oe, trdy_n_out;
  logic stop_n_out, devsel_n_out, ctl_oe, perr_n_out, perr_oe, serr_n_out;
  logic serr_oe, inta_n_out, inta_oe, req_valid;
  logic [31:0] user_rdata = 32'h0, ad_out, rd;
  pti_bus_in_t bus_in;
  pti_req_t req, got;
  int errors = 0, check_count = 0, cyc = 0, st, nperr = 0;
  pti_target dut (.clk_sys, .rst_n, .bus_in, .ad_out, .ad_oe, .par_out,
    .par_oe, .trdy_n_out, .stop_n_out, .devsel_n_out, .ctl_oe, .perr_n_out,
    .perr_oe, .serr_n_out, .serr_oe, .inta_n_out, .inta_oe, .req,
    .req_valid, .user_rdata, .user_ready, .user_stop, .user_irq, .fatal_err);
  pti_master mst (.clk_sys, .ad_oe, .par_oe, .par_out, .trdy_n_out,
    .stop_n_out, .ad_out, .bus_in);
  initial forever #5 clk_sys = ~clk_sys;
  // capture of phases, parity errors and run limit
  always @(posedge clk_sys) begin
    if (req_valid === 1'b1) got <= req;
    if (perr_oe === 1'b1 && perr_n_out === 1'b0) nperr++;
    if (++cyc == 5000) begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask
  // commands claimed or ignored by decode
  task automatic t_claim();
    logic [3:0] cm[7] = '{`PTI_CMD_MEM_WR, `PTI_CMD_MEM_WRI, `PTI_CMD_CFG_WR,
      `PTI_CMD_CFG_WR, `PTI_CMD_SPECIAL, `PTI_CMD_DAC, `PTI_CMD_MEM_WR};
    for (int i = 0; i < 7; i++) begin
      mst.xfer(cm[i], i == 6 ? 32'h2000_0010 : 32'h1000_0010, 32'h5A00_0000 + i,
        1'b1, i == 2, 1'b0, rd, st);
      chk("claim", i < 3, st);
      if (i < 3) begin
        @(negedge clk_sys);
        chk("wdata", 32'h5A00_0000 + i, got.wdata);
        chk("addr", 32'h1000_0010, got.addr);
        chk("cmd", cm[i], got.cmd);
        chk("be", 0, got.be_n);
      end
    end
  endtask
  // read line returns user data
  task automatic t_read();
    user_rdata <= 32'hA5A5_0F0F;
    mst.xfer(`PTI_CMD_MEM_RDL, 32'h1000_0020, 32'h0, 1'b0, 1'b0, 1'b0, rd, st);
    chk("rd", 32'hA5A5_0F0F, rd);
  endtask
  // target stop and bad write parity
  task automatic t_stop_perr();
    user_stop <= 1'b1;
    mst.xfer(`PTI_CMD_MEM_WR, 32'h1000_0030, 32'h1, 1'b1, 1'b0, 1'b0, rd, st);
    chk("stop", 3, st);
    user_stop <= 1'b0;
    mst.xfer(`PTI_CMD_MEM_WR, 32'h1000_0030, 32'h3, 1'b1, 1'b0, 1'b1, rd, st);
    repeat (6) @(posedge clk_sys);
    chk("perr", 1, nperr);
  endtask
  // interrupt level and system error
  task automatic t_side();
    user_irq <= 1'b1;
    fatal_err <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("inta", 2'b10, {inta_oe, inta_n_out});
    chk("serr", 1, serr_oe);
    chk("serr_n", 0, serr_n_out);
    user_irq <= 1'b0;
    fatal_err <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("inta_off", 0, inta_oe);
  endtask
  // locked pair stays with its owner
  task automatic t_lock();
    mst.m.lock_n <= 1'b0;
    repeat (2) begin
      mst.xfer(`PTI_CMD_MEM_WR, 32'h1000_0040, 32'h7, 1'b1, 1'b0, 1'b0, rd, st);
      chk("lock", 1, st);
    end
    mst.m.lock_n <= 1'b1;
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_claim();
    t_read();
    t_stop_perr();
    t_side();
    t_lock();
    complete_run();
  end
endmodule // tb

// >>> rtl/pti_pkg.sv
package pti_pkg;
  // state of the target sequencer, one-hot
  typedef enum logic [4:0] {
    PTI_IDLE = 5'b0_0001,
    PTI_DATA = 5'b0_0010,
    PTI_TURN = 5'b0_0100,
    PTI_BUSY = 5'b0_1000,
    PTI_SKIP = 5'b1_0000
  } pti_state_t;
  // bus inputs from the master, raw from pins
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0] cbe_n;
    logic par;
    logic frame_n;
    logic irdy_n;
    logic lock_n;
    logic idsel;
  } pti_bus_in_t;
  // user side data-phase request from the core
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] cmd;
    logic [3:0] be_n;
    logic [31:0] wdata;
  } pti_req_t;
endpackage

// >>> rtl/pti_regs.svh
// Operation
// - DAC 1101, MRL 1110, MWI 1111 commands
// - parity even over AD and C/BE
// - target drives read parity after TRDY
// - all signals on rising clock edge
// - reset tristates outputs, floats open drains
// - phase completes when both readies asserted
// - target asserts STOP to end transaction
// - lock accepted from one master only; the code never refuses a claim while locked, as lock_ok stays 1
// - IDSEL selects configuration accesses
// - claim decoded cycle with DEVSEL
// - interrupt line low while request pending
// - parity error two clocks after detection
// - drive parity error high before release
// - SERR on address parity; ignore special
`ifndef PTI_REGS_SVH
`define PTI_REGS_SVH
`define PTI_CMD_INTACK 4'h0
`define PTI_CMD_SPECIAL 4'h1
`define PTI_CMD_IO_RD 4'h2
`define PTI_CMD_IO_WR 4'h3
`define PTI_CMD_MEM_RD 4'h6
`define PTI_CMD_MEM_WR 4'h7
`define PTI_CMD_CFG_RD 4'hA
`define PTI_CMD_CFG_WR 4'hB
`define PTI_CMD_MEM_RDM 4'hC
`define PTI_CMD_DAC 4'hD
`define PTI_CMD_MEM_RDL 4'hE
`define PTI_CMD_MEM_WRI 4'hF
`define PTI_IDLE_AD 32'h0000_0000
`endif

// >>> rtl/pti_target.sv
`timescale 1ns/1ps
`include "pti_regs.svh"
module pti_target #(
  parameter logic [31:0] BASE_ADDR = 32'h1000_0000,
  parameter logic [31:0] BASE_MASK = 32'hFFFF_F000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pci bus from the master
  input wire pti_pkg::pti_bus_in_t bus_in,
  // pci bus driven by this target
  output logic [31:0] ad_out,
  output logic ad_oe,
  output logic par_out,
  output logic par_oe,
  // target controls, driven high one clock before release
  output logic trdy_n_out,
  output logic stop_n_out,
  output logic devsel_n_out,
  output logic ctl_oe,
  // error and interrupt pins
  output logic perr_n_out,
  output logic perr_oe,
  output logic serr_n_out,
  output logic serr_oe,
  output logic inta_n_out,
  output logic inta_oe,
  // user side
  output pti_pkg::pti_req_t req,
  output logic req_valid,
  // user side replies
  input wire logic [31:0] user_rdata,
  input wire logic user_ready,
  input wire logic user_stop,
  input wire logic user_irq,
  input wire logic fatal_err
);
  import pti_pkg::*;

  // even parity across address/data and command lines
  function automatic logic even_par(input logic [31:0] d,
                                    input logic [3:0] c);
    even_par = ^{d, c};
  endfunction

  // two flop capture of pins (b is bus_in delayed by two clocks)
  pti_bus_in_t s1_reg, b;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '1;
      b <= '1;
    end else begin
      s1_reg <= bus_in;
      b <= s1_reg;
    end
  end

  // sequencer state, captured address phase and lock ownership
  pti_state_t st_reg, st_next;
  logic frame_d_reg, is_read_reg, locked_reg, lk_own_reg;
  logic par_chk_reg, apar_chk_reg, perr1_reg, perr_hold_reg;
  logic [31:0] ad_d_reg;
  logic [3:0] cbe_d_reg;
  logic [31:0] addr_reg;
  logic [3:0] cmd_reg;

  // address phase decode
  wire start = frame_d_reg & ~b.frame_n;
  wire [3:0] cmd = b.cbe_n;
  wire is_cfg = (cmd == `PTI_CMD_CFG_RD) | (cmd == `PTI_CMD_CFG_WR);
  wire is_mem = (cmd == `PTI_CMD_MEM_RD) | (cmd == `PTI_CMD_MEM_WR) |
                (cmd == `PTI_CMD_MEM_RDM) | (cmd == `PTI_CMD_MEM_RDL) |
                (cmd == `PTI_CMD_MEM_WRI);
  wire is_rd_cmd = ~cmd[0] & (cmd != `PTI_CMD_INTACK);
  wire hit_mem = is_mem & ((b.ad & BASE_MASK) == BASE_ADDR);
  wire hit_cfg = is_cfg & b.idsel;
  wire lock_ok = ~locked_reg | lk_own_reg;
  wire claim = start & (hit_mem | hit_cfg) &
               (cmd != `PTI_CMD_SPECIAL) & (cmd != `PTI_CMD_DAC);

  // read direction known at the claim edge, before is_read_reg loads
  wire rd_now = claim ? is_rd_cmd : is_read_reg;

  // lock taken by the first locked claim, freed when bus idles unlocked
  wire lock_take = claim & ~b.lock_n & ~locked_reg;
  wire lock_free = b.frame_n & b.lock_n;

  // data phase handshake and stop request
  wire in_data = (st_reg == PTI_DATA);
  wire xfer = in_data & ~b.irdy_n & ~trdy_n_out;
  wire last = xfer & b.frame_n;
  wire stop_req = user_stop | ~lock_ok;
  wire want_stop = in_data & stop_req;

  // registered controls look one state ahead so they line up with it
  wire to_data = (st_next == PTI_DATA);
  // ready withheld once the final phase has completed
  wire trdy_now = to_data & user_ready & lock_ok & ~last;
  wire ad_drive = to_data & rd_now;
  wire ctl_drive = to_data | (st_next == PTI_TURN);

  // sequencer
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      PTI_IDLE: if (claim) st_next = PTI_DATA;
                else if (start) st_next = PTI_SKIP;
      PTI_DATA: if (last | (want_stop & b.frame_n)) st_next = PTI_TURN;
      PTI_TURN: st_next = PTI_IDLE;
      PTI_SKIP: if (b.frame_n & b.irdy_n) st_next = PTI_IDLE;
      PTI_BUSY: st_next = PTI_IDLE;
      default: st_next = PTI_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) st_reg <= PTI_IDLE;
    else st_reg <= st_next;
  end

  // address capture, lock tracking
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_d_reg <= 1'b1;
      is_read_reg <= 1'b0;
      addr_reg <= `PTI_IDLE_AD;
      cmd_reg <= '0;
      locked_reg <= 1'b0;
      lk_own_reg <= 1'b0;
    end else begin
      frame_d_reg <= b.frame_n;
      if (claim) begin
        is_read_reg <= is_rd_cmd;
        addr_reg <= b.ad;
        cmd_reg <= cmd;
      end
      // the claim that takes the lock also owns it
      if (claim) lk_own_reg <= lock_take | (locked_reg & lk_own_reg);
      else if (lock_free) lk_own_reg <= 1'b0;
      if (lock_take) locked_reg <= 1'b1;
      else if (lock_free) locked_reg <= 1'b0;
    end
  end

  // user request and data path
  assign req.addr = addr_reg;
  assign req.cmd = cmd_reg;
  assign req.be_n = b.cbe_n;
  assign req.wdata = b.ad;
  assign req_valid = xfer;

  // target control outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trdy_n_out <= 1'b1;
      stop_n_out <= 1'b1;
      devsel_n_out <= 1'b1;
      ctl_oe <= 1'b0;
      ad_out <= `PTI_IDLE_AD;
      ad_oe <= 1'b0;
    end else begin
      devsel_n_out <= ~to_data;
      trdy_n_out <= ~trdy_now;
      stop_n_out <= ~(to_data & stop_req);
      ctl_oe <= ctl_drive;
      ad_oe <= ad_drive;
      if (rd_now) ad_out <= user_rdata;
    end
  end

  // read parity lags data by one clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      par_out <= 1'b0;
      par_oe <= 1'b0;
    end else begin
      par_out <= even_par(ad_out, b.cbe_n);
      par_oe <= ad_oe;
    end
  end

  // received parity against the phase captured one clock earlier
  wire rx_par_bad = even_par(ad_d_reg, cbe_d_reg) != b.par;
  wire apar_bad = apar_chk_reg & rx_par_bad;
  // one term feeds level and enable so the open drain never drives high
  wire serr_now = apar_bad | fatal_err;

  // parity checking of received address and write data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ad_d_reg <= '0;
      cbe_d_reg <= '0;
      par_chk_reg <= 1'b0;
      apar_chk_reg <= 1'b0;
      perr1_reg <= 1'b0;
      perr_n_out <= 1'b1;
      perr_oe <= 1'b0;
      perr_hold_reg <= 1'b0;
      serr_n_out <= 1'b1;
      serr_oe <= 1'b0;
    end else begin
      ad_d_reg <= b.ad;
      cbe_d_reg <= b.cbe_n;
      apar_chk_reg <= claim;
      par_chk_reg <= xfer & ~is_read_reg;
      perr1_reg <= par_chk_reg & rx_par_bad;
      perr_n_out <= ~perr1_reg;
      perr_hold_reg <= perr1_reg;
      perr_oe <= perr1_reg | perr_hold_reg;
      serr_n_out <= ~serr_now;
      serr_oe <= serr_now;
    end
  end

  // level interrupt, open drain
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) inta_oe <= 1'b0;
    else inta_oe <= user_irq;
  end
  // open drain: only the enable moves, the level stays low
  assign inta_n_out = 1'b0;
endmodule // pti_target
